// *** hw/see_pkg.sv ***
/*
 * shared constants of the serial eeprom command engine: opcodes, word
 * sizes, serial clock divider and self-timed cycle length.
 * assumes a 10 MHz reference clock on both ends.
 */
package see_pkg;
  localparam int unsigned SEE_CLK_HZ = 10_000_000;
  // host serial clock limit, in kHz
  localparam int unsigned SEE_SK_MAX_KHZ = 250;
  localparam int unsigned SEE_SK_HALF_CYC =
    (SEE_CLK_HZ / (SEE_SK_MAX_KHZ * 1000) + 1) / 2;
  // self_timed_cycle_limit, in ms; longest time rounds down
  localparam int unsigned SEE_TPROG_MS = 10;
  localparam int unsigned SEE_PROG_CYC = SEE_CLK_HZ / 1000 * SEE_TPROG_MS;

  localparam int unsigned SEE_BYTES = 128;
  localparam int unsigned SEE_FRAME_BITS = 28;
  localparam logic [3:0] SEE_OP_READ = 4'h8;
  localparam logic [2:0] SEE_OP_PROG_LOW = 3'h4;
  localparam logic [3:0] SEE_OP_UNLOCK = 4'h3;
  localparam logic [3:0] SEE_OP_LOCK = 4'h0;
  localparam logic [3:0] SEE_OP_ERASE_ALL = 4'h2;
  localparam logic [3:0] SEE_OP_FILL_ALL = 4'h1;
  localparam logic [4:0] SEE_ABITS_W16 = 5'h06;
  localparam logic [4:0] SEE_ABITS_W8 = 5'h07;
  localparam logic [4:0] SEE_DBITS_W16 = 5'h10;
  localparam logic [4:0] SEE_DBITS_W8 = 5'h08;
  localparam logic [4:0] SEE_HDR_BITS = 5'h05;
endpackage

// *** hw/see_link_if.sv ***
/*
 * serial link between host and eeprom device.
 * assumes both ends share ref_clk_i; serial_clock is a plain signal.
 */
`timescale 1ns/100ps
`default_nettype none
interface see_link_if;
  logic cs;
  logic serial_clock;
  logic serial_in;
  logic serial_out;
  logic ready_busy;
  logic array_width_select;
  modport dev (
    input cs, serial_clock, serial_in, array_width_select,
    output serial_out, ready_busy
  );
  modport host (
    output cs, serial_clock, serial_in, array_width_select,
    input serial_out, ready_busy
  );
endinterface
`default_nettype wire

// *** hw/see_dev.sv ***
/*
 * eeprom device end: command decode, 128-byte array, read shifter and
 * self-timed erase/write engine.
 * assumes serial_clock and the other link inputs are synchronous to
 * ref_clk_i and that each serial_clock level lasts several clocks.
 */
// Contract
// - org high selects 16-bit words, 6 address bits
// - only read drives data on serial output
// - read loads addressed word into shifter
// - dummy zero precedes read data
// - serial output changes only while clock high; code also clears it on deselect, with clock low
// - host sends 8 or 16 data bits
// - program erases location then writes word
// - program phases are self-timed internally
// - ready low throughout program cycle
// - self-timed cycle ends within 10 ms
// - programming all ones erases one location
// - programming rejected until write unlock
// - unlock persists until write lock
// - read works whether locked or not
// - erase-every-word sets all bits to one
// - fill-every-word uses zero address, then data
// - fill erases all then writes every word
// - ready low throughout fill cycle
// - host serial clock at most 250 kHz
`timescale 1ns/100ps
`default_nettype none
module see_dev #(
  parameter int unsigned PROG_CYC = see_pkg::SEE_PROG_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // link
  see_link_if.dev link,
  // status
  output logic busy_o,
  output logic write_unlocked_o
);
  import see_pkg::*;

  typedef enum logic [6:0] {
    SD_IDLE = 7'h01,
    SD_OPC = 7'h02,
    SD_ADDR = 7'h04,
    SD_DATA = 7'h08,
    SD_READ = 7'h10,
    SD_BUSY = 7'h20,
    SD_DONE = 7'h40
  } see_dst_e;

  localparam logic [31:0] HALF = 32'(PROG_CYC / 2);
  localparam logic [31:0] LAST = 32'(PROG_CYC - 1);

  see_dst_e state_q;
  logic sk_q;
  logic [4:0] cnt_q;
  logic [3:0] op_q;
  logic [6:0] addr_q;
  logic [15:0] data_q;
  logic [15:0] shift_q;
  logic sout_q;
  logic rdy_q;
  logic busy_q;
  logic unlock_q;
  logic all_q;
  logic [31:0] tmr_q;
  logic [7:0] mem [SEE_BYTES];

  logic rise;
  logic wide;
  logic [4:0] abits;
  logic [4:0] dbits;
  logic [6:0] addr_d;
  logic [15:0] word;
  logic [31:0] ph;
  logic mem_we;
  logic [6:0] mem_idx;
  logic [7:0] mem_wd;

  assign rise = link.serial_clock & ~sk_q;
  assign wide = link.array_width_select;
  assign abits = wide ? SEE_ABITS_W16 : SEE_ABITS_W8;
  assign dbits = wide ? SEE_DBITS_W16 : SEE_DBITS_W8;
  assign addr_d = {addr_q[5:0], link.serial_in};

  // addressed word, 16-bit words keep the high byte at the odd index
  always_comb begin
    if (wide) begin
      word = {mem[{addr_d[5:0], 1'b1}], mem[{addr_d[5:0], 1'b0}]};
    end else begin
      word = {mem[addr_d], 8'h00};
    end
  end

  // array update: erase half first, write half second
  always_comb begin
    ph = (tmr_q < HALF) ? tmr_q : tmr_q - HALF;
    mem_we = 1'b0;
    mem_idx = ph[6:0];
    if (state_q == SD_BUSY) begin
      if (all_q) begin
        mem_we = ph < 32'(SEE_BYTES);
      end else if (wide) begin
        mem_we = ph < 32'h2;
        mem_idx = {addr_q[5:0], ph[0]};
      end else begin
        mem_we = ph == 32'h0;
        mem_idx = addr_q;
      end
    end
    if (tmr_q < HALF) begin
      mem_wd = 8'hff;
    end else if (wide && mem_idx[0]) begin
      mem_wd = data_q[15:8];
    end else begin
      mem_wd = data_q[7:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wd;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sk_q <= 1'b0;
    end else begin
      sk_q <= link.serial_clock;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= SD_IDLE;
      cnt_q <= 5'h00;
      op_q <= 4'h0;
      addr_q <= 7'h00;
      data_q <= 16'h0000;
      shift_q <= 16'h0000;
      sout_q <= 1'b0;
      rdy_q <= 1'b1;
      busy_q <= 1'b0;
      unlock_q <= 1'b0;
      all_q <= 1'b0;
      tmr_q <= 32'h0;
    end else if (state_q == SD_BUSY) begin
      // the engine runs on its own; the host clock is ignored here
      tmr_q <= tmr_q + 32'h1;
      if (tmr_q == LAST) begin
        rdy_q <= 1'b1;
        busy_q <= 1'b0;
        state_q <= SD_DONE;
      end
    end else if (!link.cs) begin
      state_q <= SD_IDLE;
      sout_q <= 1'b0;
    end else if (rise) begin
      cnt_q <= cnt_q + 5'h01;
      case (state_q)
        SD_IDLE: begin
          cnt_q <= 5'h00;
          if (link.serial_in) begin
            state_q <= SD_OPC;
          end
        end
        SD_OPC: begin
          op_q <= {op_q[2:0], link.serial_in};
          if (cnt_q == 5'h03) begin
            cnt_q <= 5'h00;
            state_q <= SD_ADDR;
          end
        end
        SD_ADDR: begin
          addr_q <= wide ? {1'b0, addr_d[5:0]} : addr_d;
          if (cnt_q == abits - 5'h01) begin
            cnt_q <= 5'h00;
            all_q <= 1'b0;
            tmr_q <= 32'h0;
            state_q <= SD_DONE;
            if (op_q == SEE_OP_READ) begin
              shift_q <= word;
              sout_q <= 1'b0;
              state_q <= SD_READ;
            end else if (op_q[2:0] == SEE_OP_PROG_LOW ||
                         op_q == SEE_OP_FILL_ALL) begin
              all_q <= op_q == SEE_OP_FILL_ALL;
              state_q <= SD_DATA;
            end else if (op_q == SEE_OP_UNLOCK) begin
              unlock_q <= 1'b1;
            end else if (op_q == SEE_OP_LOCK) begin
              unlock_q <= 1'b0;
            end else if (op_q == SEE_OP_ERASE_ALL && unlock_q) begin
              all_q <= 1'b1;
              data_q <= 16'hffff;
              rdy_q <= 1'b0;
              busy_q <= 1'b1;
              state_q <= SD_BUSY;
            end
          end
        end
        SD_DATA: begin
          data_q <= {data_q[14:0], link.serial_in};
          if (cnt_q == dbits - 5'h01) begin
            if (unlock_q) begin
              rdy_q <= 1'b0;
              busy_q <= 1'b1;
              state_q <= SD_BUSY;
            end else begin
              state_q <= SD_DONE;
            end
          end
        end
        SD_READ: begin
          sout_q <= shift_q[15];
          shift_q <= {shift_q[14:0], 1'b0};
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  assign link.serial_out = sout_q;
  assign link.ready_busy = rdy_q;
  assign busy_o = busy_q;
  assign write_unlocked_o = unlock_q;
endmodule
`default_nettype wire

// *** hw/see_host.sv ***
/*
 * host end: turns one command request into a serial frame, runs the
 * serial clock from a divider and returns read data.
 * assumes the device end is joined through see_link_if.
 */
`timescale 1ns/100ps
`default_nettype none
module see_host #(
  parameter int unsigned HALF_CYC = see_pkg::SEE_SK_HALF_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // command request
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_op_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic org16_i,
  output logic cmd_ready_o,
  // read answer
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  // link
  see_link_if.host link
);
  import see_pkg::*;

  typedef enum logic [3:0] {
    SH_IDLE = 4'h1,
    SH_LOW = 4'h2,
    SH_HIGH = 4'h4,
    SH_GAP = 4'h8
  } see_hst_e;

  localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

  see_hst_e state_q;
  logic [15:0] div_q;
  logic [SEE_FRAME_BITS-1:0] frame_q;
  logic [4:0] bit_q;
  logic [4:0] last_q;
  logic [4:0] rd_from_q;
  logic rd_q;
  logic wide_q;
  logic [15:0] rx_q;
  logic cs_q;
  logic sk_q;
  logic si_q;
  logic ready_q;
  logic valid_q;
  logic [15:0] data_q;

  logic accept;
  logic has_data;
  logic [4:0] ab;
  logic [6:0] addr_f;
  logic [SEE_FRAME_BITS-1:0] frame_d;

  assign accept = cmd_valid_i & ready_q;
  assign has_data = cmd_op_i == SEE_OP_READ || cmd_op_i == SEE_OP_FILL_ALL
                    || cmd_op_i[2:0] == SEE_OP_PROG_LOW;
  assign ab = org16_i ? SEE_ABITS_W16 : SEE_ABITS_W8;
  // fill-every-word always goes out with an all-zero address field
  assign addr_f = (cmd_op_i == SEE_OP_FILL_ALL) ? 7'h00 : cmd_addr_i;
  // wide frame is 27 bits, padded by one zero to the frame width
  assign frame_d = org16_i
    ? {1'b1, cmd_op_i, addr_f[5:0], cmd_data_i, 1'b0}
    : {1'b1, cmd_op_i, addr_f, cmd_data_i[7:0], 8'h00};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= SH_IDLE;
      div_q <= 16'h0000;
      frame_q <= '0;
      bit_q <= 5'h00;
      last_q <= 5'h00;
      rd_from_q <= 5'h00;
      rd_q <= 1'b0;
      wide_q <= 1'b1;
      rx_q <= 16'h0000;
      cs_q <= 1'b0;
      sk_q <= 1'b0;
      si_q <= 1'b0;
      ready_q <= 1'b0;
      valid_q <= 1'b0;
      data_q <= 16'h0000;
    end else begin
      valid_q <= 1'b0;
      div_q <= div_q + 16'h0001;
      case (state_q)
        SH_IDLE: begin
          wide_q <= org16_i;
          ready_q <= link.ready_busy & ~accept;
          if (accept) begin
            frame_q <= frame_d << 1;
            si_q <= frame_d[SEE_FRAME_BITS-1];
            cs_q <= 1'b1;
            div_q <= 16'h0000;
            bit_q <= 5'h00;
            last_q <= SEE_HDR_BITS + ab - 5'h01 +
                      (has_data ? (org16_i ? SEE_DBITS_W16 : SEE_DBITS_W8)
                                : 5'h00);
            rd_from_q <= SEE_HDR_BITS + ab;
            rd_q <= cmd_op_i == SEE_OP_READ;
            state_q <= SH_LOW;
          end
        end
        SH_LOW: begin
          if (div_q == HALF_LAST) begin
            div_q <= 16'h0000;
            sk_q <= 1'b1;
            state_q <= SH_HIGH;
          end
        end
        SH_HIGH: begin
          if (div_q == HALF_LAST) begin
            div_q <= 16'h0000;
            sk_q <= 1'b0;
            bit_q <= bit_q + 5'h01;
            // sampled at the end of the high level, once output settled
            if (rd_q && bit_q >= rd_from_q) begin
              rx_q <= {rx_q[14:0], link.serial_out};
            end
            if (bit_q == last_q) begin
              cs_q <= 1'b0;
              si_q <= 1'b0;
              state_q <= SH_GAP;
              valid_q <= rd_q;
              data_q <= wide_q ? {rx_q[14:0], link.serial_out}
                               : {8'h00, rx_q[6:0], link.serial_out};
            end else begin
              si_q <= frame_q[SEE_FRAME_BITS-1];
              frame_q <= frame_q << 1;
              state_q <= SH_LOW;
            end
          end
        end
        SH_GAP: begin
          if (div_q == HALF_LAST) begin
            state_q <= SH_IDLE;
          end
        end
        default: begin
          state_q <= SH_IDLE;
        end
      endcase
    end
  end

  assign link.cs = cs_q;
  assign link.serial_clock = sk_q;
  assign link.serial_in = si_q;
  assign link.array_width_select = wide_q;
  assign cmd_ready_o = ready_q;
  assign rd_valid_o = valid_q;
  assign rd_data_o = data_q;
endmodule
`default_nettype wire

// *** verif/see_link_sva.sv ***
/*
 * assertions and covers on the serial link between host and device ends.
 * assumes one reference clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module see_link_sva #(
  parameter int unsigned PROG_CYC = see_pkg::SEE_PROG_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // link
  input wire logic cs,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic ready_busy,
  input wire logic array_width_select
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  // low cycles of ready_busy so far; a counter keeps the repeat short
  logic [31:0] busy_cnt_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_cnt_q <= '0;
    end else if (ready_busy) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end

  a_out_clk_high: assert property (
    cs && $past(cs) && $changed(serial_out) |-> $past(serial_clock))
    else $error("serial out moved while serial clock low");
  a_out_idle_zero: assert property (
    !cs && !$past(cs) |-> !serial_out)
    else $error("serial out high while deselected");
  a_out_busy_zero: assert property (
    !ready_busy |-> !serial_out)
    else $error("serial out high during self-timed cycle");
  a_out_needs_sel: assert property (
    serial_out |-> $past(cs))
    else $error("serial out high without a frame");
  a_busy_exact_len: assert property (
    $rose(ready_busy) |-> busy_cnt_q == PROG_CYC)
    else $error("busy length differs from cycle length");
  a_busy_bound: assert property (
    !ready_busy |-> busy_cnt_q < PROG_CYC)
    else $error("busy longer than cycle limit");
  a_busy_in_frame: assert property (
    $fell(ready_busy) |-> $past(cs) && $past(serial_clock))
    else $error("busy began outside a clocked frame");
  a_busy_min_hold: assert property (
    $fell(ready_busy) |-> !ready_busy [*8])
    else $error("busy released too early");

  c_busy_done: cover property ($rose(ready_busy));
  c_read_one: cover property ($rose(serial_out));
  c_busy_narrow: cover property ($fell(ready_busy) && !array_width_select);
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
/*
 * testbench: host and device ends joined by the link, driven from the
 * host command port and judged by read-back and a header monitor.
 * assumes shortened cycle parameters so a run stays short.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import see_pkg::*;
  localparam int unsigned PROG = 300;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [3:0] cmd_op_i = 4'h0;
  logic [6:0] cmd_addr_i = 7'h00;
  logic [15:0] cmd_data_i = 16'h0000;
  logic org16_i = 1'b1;
  logic cmd_ready_o, rd_valid_o, busy_o, write_unlocked_o;
  logic [15:0] rd_data_o;
  logic [4:0] hdr;
  int nb = 0;
  int busy_cyc = 0;
  int errors = 0;
  int total_checks = 0;

  see_link_if see_link_if_inst ();
  see_dev #(.PROG_CYC(PROG)) see_dev_inst (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .link(see_link_if_inst.dev), .busy_o(busy_o),
    .write_unlocked_o(write_unlocked_o));
  see_host #(.HALF_CYC(4)) see_host_inst (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .org16_i(org16_i),
    .cmd_ready_o(cmd_ready_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .link(see_link_if_inst.host));
  see_link_sva #(.PROG_CYC(PROG)) see_link_sva_inst (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .cs(see_link_if_inst.cs),
    .serial_clock(see_link_if_inst.serial_clock),
    .serial_in(see_link_if_inst.serial_in),
    .serial_out(see_link_if_inst.serial_out),
    .ready_busy(see_link_if_inst.ready_busy),
    .array_width_select(see_link_if_inst.array_width_select));

  always #50 ref_clk_i = ~ref_clk_i;

  // first five bits of each frame, as the device sees them; a rising
  // chip select comes while the serial clock is low and restarts the count
  always @(posedge see_link_if_inst.cs or
           posedge see_link_if_inst.serial_clock) begin
    if (!see_link_if_inst.serial_clock) begin
      nb = 0;
    end else if (see_link_if_inst.cs && nb < 5) begin
      hdr = {hdr[3:0], see_link_if_inst.serial_in};
      nb++;
    end
  end

  // busy cycles, counted on the edge away from the one that moves busy_o
  always @(negedge ref_clk_i) begin
    if (busy_o === 1'b1) busy_cyc++;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while (cmd_ready_o !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 3000) errors++;
  endtask

  task automatic xfer(input logic [3:0] op, input logic [6:0] a,
    input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    q = 16'hxxxx;
    wait_ready();
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_data_i <= d;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b0;
    if (op == SEE_OP_READ) begin
      while (rd_valid_o !== 1'b1 && n < 1000) begin
        @(negedge ref_clk_i);
        n++;
      end
      q = rd_data_o;
      if (n >= 1000) errors++;
    end
    wait_ready();
    chk("frame header", {11'h0, hdr}, {11'h0, 1'b1, op});
  endtask

  task automatic wr(input logic [3:0] op, input logic [6:0] a,
    input logic [15:0] d);
    logic [15:0] q;
    xfer(op, a, d, q);
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] q;
    xfer(SEE_OP_READ, a, 16'h0, q);
    if (!org16_i) q = {8'h00, q[7:0]};
    chk("read data", q, exp);
  endtask

  task automatic t_erase_all();
    wr(SEE_OP_UNLOCK, 7'h00, 16'h0);
    chk("unlocked", {15'h0, write_unlocked_o}, 16'h1);
    wr(SEE_OP_ERASE_ALL, 7'h00, 16'h0);
    rd(7'h05, 16'hffff);
    rd(7'h3f, 16'hffff);
  endtask

  task automatic t_locked();
    int b0;
    wr(SEE_OP_LOCK, 7'h00, 16'h0);
    chk("locked", {15'h0, write_unlocked_o}, 16'h0);
    b0 = busy_cyc;
    wr(4'h4, 7'h05, 16'h1234);
    chk("busy cycles locked", 16'(busy_cyc - b0), 16'h0000);
    rd(7'h05, 16'hffff);
  endtask

  task automatic t_program();
    int b0;
    wr(SEE_OP_UNLOCK, 7'h00, 16'h0);
    b0 = busy_cyc;
    wr(4'h4, 7'h05, 16'ha5c3);
    chk("busy cycles", 16'(busy_cyc - b0), 16'(PROG));
    wr(4'hc, 7'h06, 16'h0f0f);
    rd(7'h05, 16'ha5c3);
    rd(7'h06, 16'h0f0f);
    wr(4'h4, 7'h05, 16'hffff);
    rd(7'h05, 16'hffff);
  endtask

  task automatic t_fill();
    wr(SEE_OP_FILL_ALL, 7'h00, 16'h5a69);
    rd(7'h00, 16'h5a69);
    rd(7'h3f, 16'h5a69);
  endtask

  task automatic t_narrow();
    @(posedge ref_clk_i);
    org16_i <= 1'b0;
    rd(7'h00, 16'h0069);
    rd(7'h7f, 16'h005a);
    wr(4'h4, 7'h03, 16'h007e);
    rd(7'h03, 16'h007e);
    wr(SEE_OP_FILL_ALL, 7'h00, 16'h00c3);
    rd(7'h7e, 16'h00c3);
    @(posedge ref_clk_i);
    org16_i <= 1'b1;
    rd(7'h01, 16'hc3c3);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_erase_all();
    t_locked();
    t_program();
    t_fill();
    t_narrow();
    final_report();
  end

  // whole run needs roughly 7000 cycles
  initial begin
    repeat (80000) @(posedge ref_clk_i);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
